// ---- include/sdwc_cfg.svh ----
// Constants for the sleep and watchdog control block
`ifndef SDWC_CFG_SVH
`define SDWC_CFG_SVH
`define SDWC_ADDR_STATUS 8'h00
`define SDWC_ADDR_WDOG_CTL 8'h01
`define SDWC_STAT_TMO_BIT 4
`define SDWC_STAT_PWD_BIT 3
`define SDWC_CTL_PS_LSB 1
`define SDWC_CTL_PS_MSB 5
`define SDWC_CTL_SWEN_BIT 0
`define SDWC_CTL_RESET 8'h16
`define SDWC_PS_RESET 5'h0B
`define SDWC_PS_MIN 5'h00
`define SDWC_PS_MAX 5'h12
`define SDWC_PS_SHIFT 5'h05
`define SDWC_OST_TOSC 1024
`define SDWC_CYC_PER_TOSC 1
`define SDWC_OST_CYC (`SDWC_OST_TOSC * `SDWC_CYC_PER_TOSC)
`endif

// ---- include/sdwc_pkg.sv ----
// Types for the sleep and watchdog control block
package sdwc_pkg;
  typedef enum logic [2:0] {
    SDWC_ST_AWAKE = 3'h1,
    SDWC_ST_ASLEEP = 3'h2,
    SDWC_ST_OST = 3'h4
  } sdwc_state_type;
  typedef enum logic [1:0] {
    SDWC_MODE_OFF = 2'h0,
    SDWC_MODE_SOFT = 2'h1,
    SDWC_MODE_AWAKE = 2'h2,
    SDWC_MODE_ALWAYS = 2'h3
  } sdwc_mode_type;
endpackage

// ---- include/sdwc_wdog_if.sv ----
// Carrier between the control logic and the watchdog counter
`timescale 1ns/1ps
interface sdwc_wdog_if;
  logic tick;
  logic clr;
  logic en;
  logic [4:0] period_sel;
  logic expire;
  logic [23:0] count;
  modport ctl (output tick, output clr, output en, output period_sel,
               input expire, input count);
  modport cnt (input tick, input clr, input en, input period_sel,
               output expire, output count);
endinterface

// ---- hw/sdwc_wdog_core.sv ----
// Watchdog tick counter with selectable power-of-two period
`timescale 1ns/1ps
`include "sdwc_cfg.svh"
module sdwc_wdog_core (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  sdwc_wdog_if.cnt bus
);
  logic [23:0] count_r;
  logic expire_r;
  logic [4:0] ps_eff;
  logic [23:0] last_cnt;
  logic hit;

  // Reserved codes fall back to the shortest period
  assign ps_eff = (bus.period_sel > `SDWC_PS_MAX) ? `SDWC_PS_MIN : bus.period_sel;
  assign last_cnt = (24'h000001 << (ps_eff + `SDWC_PS_SHIFT)) - 24'h000001;
  assign hit = bus.tick && bus.en && (count_r == last_cnt);
  assign bus.count = count_r;
  assign bus.expire = expire_r;

  // Count low-frequency ticks; clear wins over counting
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_r <= 24'h000000;
    end else if (bus.clr || hit) begin
      count_r <= 24'h000000;
    end else if (bus.tick && bus.en) begin
      count_r <= count_r + 24'h000001;
    end
  end

  // One-cycle expiry pulse
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      expire_r <= 1'b0;
    end else begin
      expire_r <= hit && !bus.clr;
    end
  end
endmodule

// ---- hw/sdwc_top.sv ----
// Sleep entry and exit control with watchdog timer
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "sdwc_cfg.svh"
module sdwc_top (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [7:0] o_rd_data,
  input wire logic i_sleep_exec,
  input wire logic i_watchdog_clear_instruction,
  input wire logic i_global_interrupt_enable,
  input wire logic [7:0] i_int_flag,
  input wire logic [7:0] i_int_enable,
  input wire logic [1:0] i_watchdog_config_mode,
  input wire logic i_osc_fail,
  input wire logic i_crystal_mode,
  input wire logic i_converter_dedicated_osc,
  input wire logic i_low_freq_internal_osc,
  input wire logic i_external_reset_pin,
  input wire logic i_external_reset_en,
  input wire logic i_brownout_reset,
  input wire logic i_brownout_reset_en,
  input wire logic i_power_on_reset,
  input wire logic [5:0] i_port_out,
  input wire logic [5:0] i_port_oe,
  output logic [5:0] o_port_out,
  output logic [5:0] o_port_oe,
  output logic o_cpu_clk_en,
  output logic o_sys_reset,
  output logic o_prefetch_next,
  output logic o_resume,
  output logic o_vector_isr,
  output logic o_asleep,
  output logic o_lf_osc_run,
  output logic o_converter_run
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  sdwc_pkg::sdwc_state_type state_r, state_nxt;
  logic [3:0] sync1_r, sync2_r;
  logic lf_prev_r;
  logic timeout_flag_n_r, power_down_flag_n_r;
  logic [4:0] watchdog_period_select_r;
  logic watchdog_soft_enable_r;
  logic [10:0] ost_cnt_r;
  logic int_wake_r;
  logic [7:0] rd_data_r;
  logic [5:0] port_out_r, port_oe_r;
  logic cpu_clk_en_r, sys_reset_r, prefetch_r, resume_r, vector_r, asleep_r;
  logic lf_run_r, conv_run_r;
  logic [3:0] async_in;
  logic lf_tick, rst_req, pending;
  logic is_awake, is_asleep, is_ost;
  logic sleep_go, sleep_nop, wake_int, wake_wdog, wake;
  logic wdog_en, wdog_rst, ost_done, resume_evt;
  logic wr_status, wr_ctl;
  logic [7:0] status_rd, ctl_rd, rd_mux;
  sdwc_wdog_if wif ();

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for pin inputs
  assign async_in = {i_power_on_reset, i_brownout_reset, i_external_reset_pin,
                     i_low_freq_internal_osc};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // Rising edge of the low-frequency oscillator gives the watchdog tick
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lf_prev_r <= 1'b0;
    end else begin
      lf_prev_r <= sync2_r[0];
    end
  end
  assign lf_tick = sync2_r[0] && !lf_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Event decode
  assign rst_req = (sync2_r[1] && i_external_reset_en)
                 || (sync2_r[2] && i_brownout_reset_en)
                 || sync2_r[3];
  assign pending = |(i_int_flag & i_int_enable);
  assign is_awake = (state_r == sdwc_pkg::SDWC_ST_AWAKE);
  assign is_asleep = (state_r == sdwc_pkg::SDWC_ST_ASLEEP);
  assign is_ost = (state_r == sdwc_pkg::SDWC_ST_OST);
  assign sleep_nop = i_sleep_exec && is_awake && !i_global_interrupt_enable
                   && pending;
  assign sleep_go = i_sleep_exec && is_awake && !sleep_nop && !rst_req && !wif.expire;
  assign wake_int = is_asleep && pending;
  assign wake_wdog = is_asleep && wif.expire;
  assign wake = (wake_int || wake_wdog) && !rst_req;
  assign wdog_rst = wif.expire && !is_asleep;
  assign ost_done = is_ost && (ost_cnt_r == 11'(`SDWC_OST_CYC - 1));
  assign resume_evt = (is_asleep && wake && !i_crystal_mode) || ost_done;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog mode decode and counter control
  always_comb begin
    unique case (sdwc_pkg::sdwc_mode_type'(i_watchdog_config_mode))
      sdwc_pkg::SDWC_MODE_ALWAYS: wdog_en = 1'b1;
      sdwc_pkg::SDWC_MODE_AWAKE: wdog_en = !is_asleep;
      sdwc_pkg::SDWC_MODE_SOFT: wdog_en = watchdog_soft_enable_r;
      sdwc_pkg::SDWC_MODE_OFF: wdog_en = 1'b0;
    endcase
  end

  assign wif.tick = lf_tick;
  assign wif.en = wdog_en;
  assign wif.period_sel = watchdog_period_select_r;
  assign wif.clr = rst_req || i_watchdog_clear_instruction || sleep_go
                 || wake || i_osc_fail || !wdog_en;

  sdwc_wdog_core u_wdog (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .bus(wif.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sleep state machine
  always_comb begin
    state_nxt = state_r;
    if (rst_req) begin
      state_nxt = sdwc_pkg::SDWC_ST_AWAKE;
    end else begin
      unique case (state_r)
        sdwc_pkg::SDWC_ST_AWAKE: begin
          if (sleep_go) begin
            state_nxt = sdwc_pkg::SDWC_ST_ASLEEP;
          end
        end
        sdwc_pkg::SDWC_ST_ASLEEP: begin
          if (wake) begin
            state_nxt = i_crystal_mode ? sdwc_pkg::SDWC_ST_OST
                                       : sdwc_pkg::SDWC_ST_AWAKE;
          end
        end
        sdwc_pkg::SDWC_ST_OST: begin
          if (ost_done) begin
            state_nxt = sdwc_pkg::SDWC_ST_AWAKE;
          end
        end
        default: state_nxt = sdwc_pkg::SDWC_ST_AWAKE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= sdwc_pkg::SDWC_ST_AWAKE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Start-up timer counts oscillator periods after a crystal wake
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ost_cnt_r <= 11'h000;
    end else if (is_ost) begin
      ost_cnt_r <= ost_cnt_r + 11'h001;
    end else begin
      ost_cnt_r <= 11'h000;
    end
  end

  // Remember whether the wake came from an interrupt
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_wake_r <= 1'b0;
    end else if (is_asleep && wake) begin
      int_wake_r <= wake_int;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: events win over each other in priority order
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timeout_flag_n_r <= 1'b1;
      power_down_flag_n_r <= 1'b1;
    end else if (rst_req) begin
      timeout_flag_n_r <= 1'b1;
      power_down_flag_n_r <= 1'b1;
    end else if (wdog_rst) begin
      timeout_flag_n_r <= 1'b0;
    end else if (wake_wdog) begin
      timeout_flag_n_r <= 1'b0;
      power_down_flag_n_r <= 1'b0;
    end else if (sleep_go) begin
      timeout_flag_n_r <= 1'b1;
      power_down_flag_n_r <= 1'b0;
    end else if (i_watchdog_clear_instruction) begin
      timeout_flag_n_r <= 1'b1;
      power_down_flag_n_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  assign wr_status = i_wr_stb && (i_addr == `SDWC_ADDR_STATUS);
  assign wr_ctl = i_wr_stb && (i_addr == `SDWC_ADDR_WDOG_CTL);
  assign status_rd = 8'h00 | (8'(timeout_flag_n_r) << `SDWC_STAT_TMO_BIT)
                   | (8'(power_down_flag_n_r) << `SDWC_STAT_PWD_BIT);
  assign ctl_rd = 8'h00 | (8'(watchdog_period_select_r) << `SDWC_CTL_PS_LSB)
                | (8'(watchdog_soft_enable_r) << `SDWC_CTL_SWEN_BIT);
  assign rd_mux = (i_addr == `SDWC_ADDR_STATUS) ? status_rd
                : (i_addr == `SDWC_ADDR_WDOG_CTL) ? ctl_rd : 8'h00;

  // Control register; flags in the status register are read-only
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      watchdog_period_select_r <= `SDWC_PS_RESET;
      watchdog_soft_enable_r <= 1'b0;
    end else if (rst_req || wdog_rst) begin
      watchdog_period_select_r <= `SDWC_PS_RESET;
      watchdog_soft_enable_r <= 1'b0;
    end else if (wr_ctl) begin
      watchdog_period_select_r <= i_wr_data[`SDWC_CTL_PS_MSB:`SDWC_CTL_PS_LSB];
      watchdog_soft_enable_r <= i_wr_data[`SDWC_CTL_SWEN_BIT];
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= i_rd_stb ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port hold and outward controls
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      port_out_r <= 6'h00;
      port_oe_r <= 6'h00;
    end else if (is_awake) begin
      port_out_r <= i_port_out;
      port_oe_r <= i_port_oe;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cpu_clk_en_r <= 1'b1;
      sys_reset_r <= 1'b0;
      prefetch_r <= 1'b0;
      resume_r <= 1'b0;
      vector_r <= 1'b0;
      asleep_r <= 1'b0;
      lf_run_r <= 1'b1;
      conv_run_r <= 1'b1;
    end else begin
      cpu_clk_en_r <= (state_nxt == sdwc_pkg::SDWC_ST_AWAKE);
      sys_reset_r <= rst_req || wdog_rst;
      prefetch_r <= i_sleep_exec && is_awake;
      resume_r <= resume_evt && !rst_req;
      vector_r <= resume_evt && !rst_req && i_global_interrupt_enable
                  && (is_ost ? int_wake_r : wake_int);
      asleep_r <= (state_nxt == sdwc_pkg::SDWC_ST_ASLEEP);
      lf_run_r <= 1'b1;
      conv_run_r <= (state_nxt == sdwc_pkg::SDWC_ST_AWAKE)
                    || i_converter_dedicated_osc;
    end
  end

  assign o_rd_data = rd_data_r;
  assign o_port_out = port_out_r;
  assign o_port_oe = port_oe_r;
  assign o_cpu_clk_en = cpu_clk_en_r;
  assign o_sys_reset = sys_reset_r;
  assign o_prefetch_next = prefetch_r;
  assign o_resume = resume_r;
  assign o_vector_isr = vector_r;
  assign o_asleep = asleep_r;
  assign o_lf_osc_run = lf_run_r;
  assign o_converter_run = conv_run_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_enter;
    is_awake && i_sleep_exec && !sleep_nop && !rst_req && !wif.expire;
  endsequence
  sequence s_asleep_flags;
    is_asleep && !power_down_flag_n_r && timeout_flag_n_r;
  endsequence

  property p_sleep_by_instr;
    (is_asleep && !$past(is_asleep)) |-> $past(i_sleep_exec);
  endproperty
  a_sleep_by_instr: assert property (p_sleep_by_instr) else $error("sleep without instr");

  property p_entry_flags;
    s_enter |=> s_asleep_flags;
  endproperty
  a_entry_flags: assert property (p_entry_flags) else $error("bad entry flags");

  property p_sleep_nop;
    sleep_nop && !rst_req && !wif.expire |=> is_awake && $stable(timeout_flag_n_r)
      && $stable(power_down_flag_n_r);
  endproperty
  a_sleep_nop: assert property (p_sleep_nop) else $error("nop sleep changed state");

  property p_clk_gate;
    (o_cpu_clk_en == is_awake) and ($rose(o_cpu_clk_en) |-> o_resume || o_sys_reset);
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("core clock not gated");

  property p_port_hold;
    !is_awake |=> $stable(o_port_out) && $stable(o_port_oe);
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("port changed in sleep");

  property p_wake_clear;
    wake |=> (wif.count == 24'h000000) && !is_asleep;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake did not clear");

  property p_int_wake;
    is_asleep && pending |=> !is_asleep;
  endproperty
  a_int_wake: assert property (p_int_wake) else $error("no interrupt wake");

  property p_ost_end;
    is_ost && !rst_req |=> (o_cpu_clk_en == $past(ost_done));
  endproperty
  a_ost_end: assert property (p_ost_end) else $error("start-up delay wrong");

  property p_wdog_reset;
    wif.expire && !is_asleep |=> o_sys_reset && !timeout_flag_n_r;
  endproperty
  a_wdog_reset: assert property (p_wdog_reset) else $error("no watchdog reset");

  property p_sleep_expire;
    wif.expire && is_asleep && !rst_req |=> !o_sys_reset && !is_asleep
      && !timeout_flag_n_r && !power_down_flag_n_r;
  endproperty
  a_sleep_expire: assert property (p_sleep_expire) else $error("sleep expiry reset");

  property p_mode_off;
    i_watchdog_config_mode == 2'h0 |=> wif.count == 24'h000000;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("disabled watchdog counts");
endmodule

// ---- dv/sdwc_core_model.sv ----
// Behavioural processor core issuing sleep and watchdog-clear instructions
`timescale 1ns/1ps
module sdwc_core_model (
  input wire logic i_ref_clk,
  input wire logic i_cpu_clk_en,
  output logic o_sleep_exec,
  output logic o_clear,
  output logic [5:0] o_port_out,
  output logic [5:0] o_port_oe
);
  initial begin
    o_sleep_exec = 1'b0;
    o_clear = 1'b0;
    o_port_out = 6'h00;
    o_port_oe = 6'h2A;
  end
  ////////////////////////////////////////////////////////////////
  // Port pattern changes every cycle so a frozen output is visible
  always @(posedge i_ref_clk) begin
    o_port_out <= o_port_out + 6'h01;
    o_port_oe <= ~o_port_oe;
  end
  ////////////////////////////////////////////////////////////////
  // One instruction pulse; nothing issues while the core clock is gated
  task automatic issue(input logic slp);
    @(posedge i_ref_clk);
    while (i_cpu_clk_en !== 1'b1) @(posedge i_ref_clk);
    if (slp) begin
      o_sleep_exec <= 1'b1;
    end else begin
      o_clear <= 1'b1;
    end
    @(posedge i_ref_clk);
    o_sleep_exec <= 1'b0;
    o_clear <= 1'b0;
  endtask
endmodule

// ---- dv/sleep_and_watchdog_control_tb.sv ----
// Self-checking bench for the sleep and watchdog control block
`timescale 1ns/1ps
module sleep_and_watchdog_control_tb;
  logic clk, rst_n, wr, rds, global_interrupt_enable, oscf, xtal, conv, lf, ext, ext_en, bor, bor_en, por;
  logic [7:0] addr, wdata, flag, en, rdata;
  logic [1:0] mode;
  logic sexec, clr, clk_en, sys_rst, pref, resume, vec, asleep, lfrun, convrun, last_vec;
  logic [5:0] pin, poe, pout, pooe, p0, p1;
  int error_cnt, total_checks, cyc, n, rst_hits;

  sdwc_top sdwc_top_i (.i_ref_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_stb(wr), .i_rd_stb(rds), .o_rd_data(rdata), .i_sleep_exec(sexec),
    .i_watchdog_clear_instruction(clr), .i_global_interrupt_enable(global_interrupt_enable), .i_int_flag(flag),
    .i_int_enable(en), .i_watchdog_config_mode(mode), .i_osc_fail(oscf),
    .i_crystal_mode(xtal), .i_converter_dedicated_osc(conv), .i_low_freq_internal_osc(lf),
    .i_external_reset_pin(ext), .i_external_reset_en(ext_en), .i_brownout_reset(bor),
    .i_brownout_reset_en(bor_en), .i_power_on_reset(por), .i_port_out(pin), .i_port_oe(poe),
    .o_port_out(pout), .o_port_oe(pooe), .o_cpu_clk_en(clk_en), .o_sys_reset(sys_rst),
    .o_prefetch_next(pref), .o_resume(resume), .o_vector_isr(vec), .o_asleep(asleep),
    .o_lf_osc_run(lfrun), .o_converter_run(convrun));
  sdwc_core_model sdwc_core_model_i (.i_ref_clk(clk), .i_cpu_clk_en(clk_en),
    .o_sleep_exec(sexec), .o_clear(clr), .o_port_out(pin), .o_port_oe(poe));

  ////////////////////////////////////////////////////////////////
  // Reference clock, slow oscillator (tick every 8 cycles), timeout
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    forever begin
      repeat (4) @(posedge clk);
      lf <= ~lf;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (sys_rst === 1'b1) rst_hits++;
    if (cyc == 12000) begin
      error_cnt++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Comparison, bus and wait helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rds <= 1'b1;
    @(posedge clk);
    rds <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask
  task automatic wait_hi(input bit s, input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (((s ? sys_rst : resume) !== 1'b1) && k < lim);
    last_vec = vec;
  endtask
  task automatic intr(input logic [7:0] f, input logic [7:0] e);
    @(posedge clk);
    flag <= f;
    en <= e;
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    rd_reg(8'h00, 8'h18, 8'hFF);
    rd_reg(8'h01, 8'h16, 8'hFF);
    wr_reg(8'h00, 8'h00);
    rd_reg(8'h00, 8'h18, 8'hFF);
    rd_reg(8'h07, 8'h00, 8'hFF);
    wr_reg(8'h01, 8'hFF);
    rd_reg(8'h01, 8'h3F, 8'hFF);
    wr_reg(8'h01, 8'h16);
    $display("t_regs done");
  endtask
  task automatic t_sleep_gie1();
    global_interrupt_enable <= 1'b1;
    sdwc_core_model_i.issue(1'b1);
    #1;
    p0 = pout;
    p1 = pooe;
    chk(asleep, 1);
    chk(clk_en, 0);
    chk(pref, 1);
    chk(convrun, 0);
    chk(lfrun, 1);
    rd_reg(8'h00, 8'h10, 8'hFF);
    intr(8'h01, 8'h00);
    repeat (10) @(posedge clk);
    #1;
    chk(pout, p0);
    chk(pooe, p1);
    chk(asleep, 1);
    intr(8'h01, 8'h01);
    wait_hi(1'b0, 6, n);
    chk(resume, 1);
    chk(last_vec, 1);
    chk(clk_en, 1);
    intr(8'h00, 8'h00);
    sdwc_core_model_i.issue(1'b0);
    rd_reg(8'h00, 8'h18, 8'hFF);
    $display("t_sleep_gie1 done");
  endtask
  task automatic t_sleep_gie0();
    global_interrupt_enable <= 1'b0;
    conv <= 1'b1;
    sdwc_core_model_i.issue(1'b1);
    #1;
    chk(convrun, 1);
    intr(8'h02, 8'h02);
    wait_hi(1'b0, 6, n);
    chk(resume, 1);
    chk(last_vec, 0);
    sdwc_core_model_i.issue(1'b1);
    #1;
    chk(pref, 1);
    chk(asleep, 0);
    rd_reg(8'h00, 8'h10, 8'hFF);
    intr(8'h00, 8'h00);
    conv <= 1'b0;
    sdwc_core_model_i.issue(1'b0);
    $display("t_sleep_gie0 done");
  endtask
  task automatic t_xtal();
    xtal <= 1'b1;
    sdwc_core_model_i.issue(1'b1);
    intr(8'h04, 8'h04);
    wait_hi(1'b0, 1100, n);
    chk(n >= 1024 && n < 1030, 1);
    intr(8'h00, 8'h00);
    xtal <= 1'b0;
    sdwc_core_model_i.issue(1'b0);
    $display("t_xtal done");
  endtask
  task automatic t_wdog();
    mode <= 2'h1;
    wr_reg(8'h01, 8'h01);
    wait_hi(1'b1, 400, n);
    chk(n >= 240 && n <= 275, 1);
    rd_reg(8'h01, 8'h16, 8'hFF);
    rd_reg(8'h00, 8'h00, 8'h10);
    mode <= 2'h0;
    wr_reg(8'h01, 8'h01);
    rst_hits = 0;
    repeat (400) @(posedge clk);
    chk(rst_hits == 0, 1);
    mode <= 2'h3;
    wr_reg(8'h01, 8'h00);
    for (int i = 0; i < 8; i++) begin
      repeat (150) @(posedge clk);
      if (i[0]) begin
        oscf <= 1'b1;
        @(posedge clk);
        oscf <= 1'b0;
      end else begin
        sdwc_core_model_i.issue(1'b0);
      end
    end
    chk(rst_hits == 0, 1);
    sdwc_core_model_i.issue(1'b1);
    wait_hi(1'b0, 400, n);
    chk(resume, 1);
    mode <= 2'h2;
    chk(rst_hits == 0, 1);
    rd_reg(8'h00, 8'h00, 8'hFF);
    sdwc_core_model_i.issue(1'b1);
    repeat (400) @(posedge clk);
    #1;
    chk(asleep, 1);
    chk(rst_hits == 0, 1);
    intr(8'h08, 8'h08);
    wait_hi(1'b0, 6, n);
    chk(resume, 1);
    mode <= 2'h0;
    intr(8'h00, 8'h00);
    sdwc_core_model_i.issue(1'b0);
    $display("t_wdog done");
  endtask
  task automatic t_resets();
    for (int i = 0; i < 3; i++) begin
      sdwc_core_model_i.issue(1'b1);
      @(posedge clk);
      ext <= (i == 0);
      bor <= (i == 1);
      por <= (i == 2);
      repeat (6) @(posedge clk);
      #1;
      chk(sys_rst, i == 2);
      @(posedge clk);
      ext_en <= 1'b1;
      bor_en <= 1'b1;
      wait_hi(1'b1, 8, n);
      chk(n < 8, 1);
      @(posedge clk);
      ext <= 1'b0;
      bor <= 1'b0;
      por <= 1'b0;
      ext_en <= 1'b0;
      bor_en <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk(asleep, 0);
      rd_reg(8'h00, 8'h18, 8'hFF);
    end
    $display("t_resets done");
  endtask

  ////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rds = 1'b0;
    global_interrupt_enable = 1'b0;
    oscf = 1'b0;
    xtal = 1'b0;
    conv = 1'b0;
    lf = 1'b0;
    ext = 1'b0;
    ext_en = 1'b0;
    bor = 1'b0;
    bor_en = 1'b0;
    por = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    flag = 8'h00;
    en = 8'h00;
    mode = 2'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_sleep_gie1();
    t_sleep_gie0();
    t_xtal();
    t_wdog();
    t_resets();
    print_verdict();
  end
endmodule
